// file: bench/rx_serdes_chan_a_irq_enable_tb_top.sv
// Testbench: register calls and receiver bits against the channel A block.
// Assumes the host model performs every register access.
`timescale 1ns/10ps
module rx_serdes_chan_a_irq_enable_tb_top;
	logic                  core_clk_i;
	logic                  rst_n_i;
	logic                  irq_o;
	rxaiq_pkg::rxaiq_req_s req;
	rxaiq_pkg::rxaiq_bit_s bit_v;
	logic [7:0]            rdata;
	logic [7:0]            d;
	logic [2:0]            eof_len;
	int                    n_mismatch = 0;
	int                    cmp_count = 0;

	rxaiq_core #(.EOF_LEN_W(3)) i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.req_i(req), .rdata_o(rdata), .bit_i(bit_v), .eof_len_i(eof_len), .irq_o(irq_o));
	rxaiq_host_model i_host (.core_clk_i(core_clk_i), .req_o(req), .rdata_i(rdata));

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic check(input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("unexpected at %0t seen %h expected %h", $time, s, e);
		end
	endtask : check

	task automatic final_report();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : final_report

	// Sends n bits MSB first; a pause after lets sticky flags land.
	task automatic send(input logic [7:0] v, input int n, input logic ok);
		for (int i = n - 1; i >= 0; i--) begin
			@(posedge core_clk_i);
			#1 bit_v = '{stb: 1'b1, ok: ok, data: v[i]};
		end
		@(posedge core_clk_i);
		#1 bit_v = '0;
		repeat (2) @(posedge core_clk_i);
		#1;
	endtask : send

	task automatic rchk(input logic [5:0] a, input logic [7:0] e);
		i_host.rd(a, d);
		check(d, e);
	endtask : rchk

	// Free-running clock at 20 MHz.
	initial begin
		core_clk_i = 1'b0;
		forever #25 core_clk_i = ~core_clk_i;
	end

	// Watchdog; the tests need about 110 cycles, so this margin is ample.
	initial begin
		repeat (3000) @(posedge core_clk_i);
		n_mismatch++;
		final_report();
	end

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		rst_n_i = 1'b0;
		bit_v = '0;
		eof_len = 3'h0;
		repeat (8) @(posedge core_clk_i);
		#1 rst_n_i = 1'b1;
		check({7'h00, irq_o}, 8'h00);
		rchk(rxaiq_pkg::ADDR_IEN, 8'h00);
		rchk(6'h3f, 8'h00);
		send(8'h00, 2, 1'b0);
		rchk(rxaiq_pkg::ADDR_STAT, 8'h00);
		$display("test reset done");
		i_host.wr(rxaiq_pkg::ADDR_IEN, 8'h08);
		i_host.rd(rxaiq_pkg::ADDR_DATA, d);
		check({7'h00, irq_o}, 8'h01);
		rchk(rxaiq_pkg::ADDR_STAT, 8'h04);
		check({7'h00, irq_o}, 8'h00);
		$display("test underflow done");
		i_host.wr(rxaiq_pkg::ADDR_IEN, 8'h00);
		send(8'ha5, 8, 1'b1);
		check({7'h00, irq_o}, 8'h00);
		i_host.wr(rxaiq_pkg::ADDR_IEN, 8'h01);
		check({7'h00, irq_o}, 8'h01);
		i_host.wr(rxaiq_pkg::ADDR_DATA, 8'h00);
		rchk(rxaiq_pkg::ADDR_DATA, 8'ha5);
		check({7'h00, irq_o}, 8'h00);
		$display("test full done");
		i_host.wr(rxaiq_pkg::ADDR_IEN, 8'h04);
		send(8'h3c, 8, 1'b1);
		send(8'hc3, 8, 1'b1);
		check({7'h00, irq_o}, 8'h01);
		rchk(rxaiq_pkg::ADDR_STAT, 8'h0d);
		check({7'h00, irq_o}, 8'h00);
		rchk(rxaiq_pkg::ADDR_DATA, 8'hc3);
		$display("test overflow done");
		i_host.wr(rxaiq_pkg::ADDR_IEN, 8'h02);
		send(8'h05, 3, 1'b1);
		send(8'h00, 1, 1'b0);
		check({7'h00, irq_o}, 8'h01);
		repeat (4) @(posedge core_clk_i);
		#1;
		check({7'h00, irq_o}, 8'h01);
		rchk(rxaiq_pkg::ADDR_STAT, 8'h03);
		check({7'h00, irq_o}, 8'h00);
		rchk(rxaiq_pkg::ADDR_DATA, 8'h05);
		$display("test eof zero done");
		eof_len = 3'h2;
		send(8'h01, 1, 1'b1);
		send(8'h00, 2, 1'b0);
		check({7'h00, irq_o}, 8'h00);
		send(8'h00, 1, 1'b0);
		check({7'h00, irq_o}, 8'h01);
		rchk(rxaiq_pkg::ADDR_STAT, 8'h03);
		rchk(rxaiq_pkg::ADDR_DATA, 8'h01);
		$display("test eof length done");
		final_report();
	end
endmodule : rx_serdes_chan_a_irq_enable_tb_top

// file: bench/rxaiq_host_model.sv
// Host model: issues register reads and writes as the access engine would.
// Assumes the device takes a request on the rising edge of core_clk_i.
`timescale 1ns/10ps
module rxaiq_host_model (
	// Clock.
	input  wire logic             core_clk_i,
	// Register access.
	output rxaiq_pkg::rxaiq_req_s req_o,
	input  wire logic [7:0]       rdata_i
);
	// Idle at time zero, so nothing is taken before the first access.
	initial begin
		req_o = '0;
	end

	// One write; an edge passes first so strobes never merge back to back.
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		#1 req_o = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(posedge core_clk_i);
		#1 req_o = '0;
	endtask : wr

	// One read; data lands at the taking edge, so it is settled one step later.
	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		@(posedge core_clk_i);
		#1 req_o = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		@(posedge core_clk_i);
		#1 req_o = '0;
		d = rdata_i;
	endtask : rd
endmodule : rxaiq_host_model

// file: pkg/rxaiq_pkg.sv
// Shared constants and carriers for the channel A receive interrupt block.
// Assumes a register access engine outside that turns host serial frames
// into one-cycle read and write strobes with a six-bit address.
// ****************************************************************
// Overview of operation
// R1 - Enable bit 3 gates the underflow interrupt of the channel A data register.
// R2 - Reading the channel A data register while it holds no unread byte flags underflow.
// R3 - Enable bit 1 gates the channel A end-of-frame interrupt.
// R4 - After one valid bit, end of frame is declared once invalid bits exceed the length.
// R5 - With a length of zero, the first invalid bit after valid reception ends the frame.
// R6 - The end-of-frame flag holds until the host reads the status register.
// R7 - Enable bit 0 gates the interrupt for data arriving in the channel A data register.
// R8 - Each transfer from the receiver into the data register flags the full condition.
// R9 - The receiver transfers on a whole byte or on end of frame with a partial byte.
// R10 - Enable bit 2 gates overflow, raised when new data lands before the old was read.
// R11 - The interrupt output is high while any enabled channel A condition is active.
// ****************************************************************
package rxaiq_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [5:0] ADDR_IEN  = 6'h07;
	localparam logic [5:0] ADDR_STAT = 6'h08;
	localparam logic [5:0] ADDR_DATA = 6'h09;
	localparam logic [7:0] IEN_RESET = 8'h00;

	// Enable and status bit positions.
	localparam int BIT_FULL  = 0;
	localparam int BIT_EOF   = 1;
	localparam int BIT_OVF   = 2;
	localparam int BIT_UDF   = 3;
	localparam int BIT_FLOW  = 2;
	localparam int BIT_VALID = 3;

	// Index of the last bit in one received byte.
	localparam logic [3:0] BYTE_LAST = 4'h7;

	// One register request from the access engine.
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [5:0] addr;
		logic [7:0] wdata;
	} rxaiq_req_s;

	// One decoded bit from the channel A receiver.
	typedef struct packed {
		logic stb;
		logic ok;
		logic data;
	} rxaiq_bit_s;

endpackage : rxaiq_pkg

// file: rtl/rxaiq_core.sv
// Channel A receive data register, its four conditions and the interrupt line.
// Assumes register strobes and receiver bit strobes are synchronous to
// core_clk_i, and that the end-of-frame length comes from neighbouring logic.
`timescale 1ns/10ps
module rxaiq_core #(
	parameter int EOF_LEN_W = 3
) (
	// Clock and reset.
	input  wire logic                     core_clk_i,
	input  wire logic                     rst_n_i,
	// Register access.
	input  wire rxaiq_pkg::rxaiq_req_s    req_i,
	output logic [7:0]                    rdata_o,
	// Receiver bits and frame configuration.
	input  wire rxaiq_pkg::rxaiq_bit_s    bit_i,
	input  wire logic [EOF_LEN_W-1:0]     eof_len_i,
	// Interrupt to the host.
	output logic                          irq_o
);

	// ****************************************************************
	// Parameter check
	// ****************************************************************
	if (EOF_LEN_W < 1 || EOF_LEN_W > 8) begin : g_chk
		$error("EOF_LEN_W must lie between 1 and 8.");
	end

	// ****************************************************************
	// State
	// ****************************************************************
	logic [7:0]           ien;
	logic [7:0]           shift;
	logic [3:0]           nbits;
	logic                 seen;
	logic [EOF_LEN_W:0]   inv_cnt;
	logic [7:0]           data_q;
	logic                 full_q;
	logic                 eof_q;
	logic                 ovf_q;
	logic                 udf_q;
	logic                 valid_q;

	// ****************************************************************
	// Decode
	// ****************************************************************
	logic                 rd_data;
	logic                 rd_stat;
	logic                 valid_bit;
	logic                 inval_bit;
	logic                 byte_done;
	logic                 eof_evt;
	logic                 xfer;
	logic [7:0]           next_shift;
	logic [EOF_LEN_W:0]   next_inv;
	logic [3:0]           cond;
	logic [7:0]           stat_word;

	// Access strobes for the two registers with read side effects.
	assign rd_data = req_i.rd && (req_i.addr == rxaiq_pkg::ADDR_DATA);
	assign rd_stat = req_i.rd && (req_i.addr == rxaiq_pkg::ADDR_STAT);

	// Invalid bits only count once a frame has started with a valid bit.
	assign valid_bit  = bit_i.stb && bit_i.ok;
	assign inval_bit  = bit_i.stb && !bit_i.ok && seen;
	assign next_shift = {shift[6:0], bit_i.data};
	assign next_inv   = inv_cnt + {{EOF_LEN_W{1'b0}}, 1'b1};
	assign byte_done  = valid_bit && (nbits == rxaiq_pkg::BYTE_LAST);
	// A zero length fires on the first invalid bit since the count then exceeds it.
	assign eof_evt    = inval_bit && (next_inv > {1'b0, eof_len_i}); // R4 R5
	// A partial byte is handed over at end of frame; an empty one is not.
	assign xfer       = byte_done || (eof_evt && (nbits != 4'h0)); // R9

	// ****************************************************************
	// Enable register
	// ****************************************************************
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			ien <= rxaiq_pkg::IEN_RESET;
		end else if (req_i.wr && (req_i.addr == rxaiq_pkg::ADDR_IEN)) begin
			ien <= req_i.wdata; // R1 R3 R7 R10
		end
	end

	// ****************************************************************
	// Bit assembly and frame tracking
	// ****************************************************************
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			shift   <= 8'h00;
			nbits   <= 4'h0;
			seen    <= 1'b0;
			inv_cnt <= '0;
		end else if (valid_bit) begin
			// Clear on a whole byte, so a later partial byte reads with zeros above it.
			shift   <= byte_done ? 8'h00 : next_shift;
			nbits   <= byte_done ? 4'h0 : nbits + 4'h1;
			seen    <= 1'b1;
			inv_cnt <= '0;
		end else if (eof_evt) begin
			shift   <= 8'h00;
			nbits   <= 4'h0;
			seen    <= 1'b0; // R4
			inv_cnt <= '0;
		end else if (inval_bit) begin
			inv_cnt <= next_inv; // R4
		end
	end

	// ****************************************************************
	// Data register and its occupancy
	// ****************************************************************
	// A read in the same cycle as a transfer takes the old byte, so no overflow.
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			data_q  <= 8'h00;
			full_q  <= 1'b0;
			valid_q <= 1'b0;
		end else if (xfer) begin
			data_q  <= byte_done ? next_shift : shift; // R9
			full_q  <= 1'b1; // R8
			valid_q <= byte_done;
		end else if (rd_data) begin
			full_q  <= 1'b0;
		end
	end

	// ****************************************************************
	// Sticky conditions
	// ****************************************************************
	// Setting wins over a status read in the same cycle, so no event is lost.
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			eof_q <= 1'b0;
			ovf_q <= 1'b0;
			udf_q <= 1'b0;
		end else begin
			if (eof_evt) begin
				eof_q <= 1'b1; // R4
			end else if (rd_stat) begin
				eof_q <= 1'b0; // R6
			end
			if (xfer && full_q && !rd_data) begin
				ovf_q <= 1'b1; // R10
			end else if (rd_stat) begin
				ovf_q <= 1'b0;
			end
			if (rd_data && !full_q) begin
				udf_q <= 1'b1; // R2
			end else if (rd_stat) begin
				udf_q <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Read data and interrupt
	// ****************************************************************
	// Status assembled by field position, so the layout lives in the package alone.
	always_comb begin
		stat_word                       = 8'h00;
		stat_word[rxaiq_pkg::BIT_FULL]  = full_q;
		stat_word[rxaiq_pkg::BIT_EOF]   = eof_q;
		stat_word[rxaiq_pkg::BIT_FLOW]  = ovf_q | udf_q;
		stat_word[rxaiq_pkg::BIT_VALID] = valid_q;
	end

	// Unmapped addresses read as zero.
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			rdata_o <= 8'h00;
		end else if (req_i.rd) begin
			unique case (req_i.addr)
				rxaiq_pkg::ADDR_IEN:  rdata_o <= ien;
				rxaiq_pkg::ADDR_STAT: rdata_o <= stat_word;
				rxaiq_pkg::ADDR_DATA: rdata_o <= data_q;
				default:              rdata_o <= 8'h00;
			endcase
		end
	end

	// The line is a level built from flops, so it stays until the cause is cleared.
	assign cond  = {udf_q, ovf_q, eof_q, full_q};
	assign irq_o = |(cond & ien[3:0]); // R1 R3 R7 R10 R11

	// ****************************************************************
	// Assertions
	// ****************************************************************
	// All checks share the core clock and stay silent while reset is held.
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_udf_gate;
		udf_q && !ien[rxaiq_pkg::BIT_UDF] && !ovf_q && !eof_q && !full_q |-> !irq_o;
	endproperty
	a_udf_gate: assert property (p_udf_gate) else $error("Underflow not gated."); // R1

	property p_udf_set;
		rd_data && !full_q |=> udf_q && rdata_o == $past(data_q);
	endproperty
	a_udf_set: assert property (p_udf_set) else $error("Underflow missed."); // R2

	property p_eof_gate;
		eof_q && ien[rxaiq_pkg::BIT_EOF] |-> irq_o;
	endproperty
	a_eof_gate: assert property (p_eof_gate) else $error("EOF not raised."); // R3

	property p_eof_len;
		inval_bit && ({1'b0, eof_len_i} == inv_cnt) |=> eof_q && !seen;
	endproperty
	a_eof_len: assert property (p_eof_len) else $error("EOF length wrong."); // R4

	property p_eof_zero;
		inval_bit && (eof_len_i == '0) |=> eof_q;
	endproperty
	a_eof_zero: assert property (p_eof_zero) else $error("EOF zero length."); // R5

	property p_eof_hold;
		eof_q && !rd_stat |=> eof_q;
	endproperty
	a_eof_hold: assert property (p_eof_hold) else $error("EOF dropped."); // R6

	property p_full_gate;
		full_q && ien[rxaiq_pkg::BIT_FULL] |-> irq_o;
	endproperty
	a_full_gate: assert property (p_full_gate) else $error("Full not raised."); // R7

	property p_full_set;
		byte_done |=> full_q && data_q == $past(next_shift);
	endproperty
	a_full_set: assert property (p_full_set) else $error("Byte not moved."); // R8 R9

	property p_ovf_set;
		xfer && full_q && !rd_data |=> ovf_q;
	endproperty
	a_ovf_set: assert property (p_ovf_set) else $error("Overflow missed."); // R10

	property p_irq_quiet;
		ien[3:0] == 4'h0 |-> !irq_o;
	endproperty
	a_irq_quiet: assert property (p_irq_quiet) else $error("Stray interrupt."); // R11

	// Clearing, gating and counting checks for corners that tests seldom reach.
	property p_eof_clear;
		rd_stat && !eof_evt |=> !eof_q;
	endproperty
	a_eof_clear: assert property (p_eof_clear) else $error("EOF not cleared."); // R6

	property p_eof_early;
		inval_bit && !eof_q && ({1'b0, eof_len_i} > inv_cnt) |=> !eof_q;
	endproperty
	a_eof_early: assert property (p_eof_early) else $error("EOF too early."); // R4

	property p_eof_idle;
		bit_i.stb && !bit_i.ok && !seen |=> inv_cnt == $past(inv_cnt);
	endproperty
	a_eof_idle: assert property (p_eof_idle) else $error("Idle invalid bit counted."); // R4

	property p_full_clear;
		rd_data && !xfer |=> !full_q;
	endproperty
	a_full_clear: assert property (p_full_clear) else $error("Full not cleared."); // R8

	property p_part_move;
		eof_evt && (nbits != 4'h0) |=> full_q && !valid_q && data_q == $past(shift);
	endproperty
	a_part_move: assert property (p_part_move) else $error("Partial byte not moved."); // R9

	property p_valid_byte;
		byte_done |=> valid_q;
	endproperty
	a_valid_byte: assert property (p_valid_byte) else $error("Whole byte not marked."); // R9

	property p_ovf_gate;
		ovf_q && ien[rxaiq_pkg::BIT_OVF] |-> irq_o;
	endproperty
	a_ovf_gate: assert property (p_ovf_gate) else $error("Overflow not raised."); // R10

	property p_ovf_none;
		xfer && !full_q && !ovf_q |=> !ovf_q;
	endproperty
	a_ovf_none: assert property (p_ovf_none) else $error("Overflow without cause."); // R10

	property p_udf_raise;
		udf_q && ien[rxaiq_pkg::BIT_UDF] |-> irq_o;
	endproperty
	a_udf_raise: assert property (p_udf_raise) else $error("Underflow not raised."); // R1

	property p_udf_none;
		rd_data && full_q && !udf_q |=> !udf_q;
	endproperty
	a_udf_none: assert property (p_udf_none) else $error("Underflow without cause."); // R2

	property p_ien_write;
		req_i.wr && (req_i.addr == rxaiq_pkg::ADDR_IEN) |=> ien == $past(req_i.wdata);
	endproperty
	a_ien_write: assert property (p_ien_write) else $error("Enable not written."); // R7

	// Covers for the main scenarios: byte, partial byte, overflow, underflow, end of frame.
	c_byte:  cover property (byte_done ##[1:20] rd_data);
	c_part:  cover property (eof_evt && nbits != 4'h0);
	c_ovf:   cover property (xfer && full_q && !rd_data);
	c_udf:   cover property (rd_data && !full_q);
	c_eof:   cover property (eof_evt && ien[rxaiq_pkg::BIT_EOF]);

endmodule : rxaiq_core
